//--- fpuie_defines.vh
// Constants for the invalid-operation exception unit.
// Included by every design file of the block.
`ifndef FPUIE_DEFINES_VH
`define FPUIE_DEFINES_VH
`define FPUIE_ADDR_STATUS 8'h00
`define FPUIE_ADDR_CONTROL 8'h04
`define FPUIE_ADDR_TAG 8'h08
`define FPUIE_ADDR_TOP 8'h0C
`define FPUIE_ADDR_OPCMD 8'h10
`define FPUIE_ADDR_OPA 8'h14
`define FPUIE_ADDR_RESULT 8'h18
`define FPUIE_ADDR_EVENT 8'h1C
`define FPUIE_BIT_INVALID 0
`define FPUIE_BIT_STACK_FAULT 6
`define FPUIE_BIT_SUMMARY 7
`define FPUIE_BIT_COND_ZERO 8
`define FPUIE_BIT_COND_ONE 9
`define FPUIE_BIT_COND_TWO 10
`define FPUIE_BIT_COND_THREE 14
`define FPUIE_BIT_MASK 0
`define FPUIE_STATUS_RESET 16'h0000
`define FPUIE_CONTROL_RESET 16'h0001
`define FPUIE_TAG_RESET 16'hFFFF
`define FPUIE_TAG_EMPTY 2'b11
`define FPUIE_QNAN_INDEF 32'hFFC0_0000
`define FPUIE_INT_INDEF 32'h8000_0000
`define FPUIE_BCD_INDEF 32'hFFFF_C000
`define FPUIE_OP_LOAD 4'h1
`define FPUIE_OP_STORE_FP 4'h2
`define FPUIE_OP_STORE_INT 4'h3
`define FPUIE_OP_STORE_BCD 4'h4
`define FPUIE_OP_ARITH 4'h5
`define FPUIE_OP_COMPARE 4'h6
`define FPUIE_OP_EXCHANGE 4'h7
`define FPUIE_OP_NONARITH 4'h8
`define FPUIE_CAUSE_UNSUP 0
`define FPUIE_CAUSE_SNAN 1
`define FPUIE_CAUSE_QNAN 2
`define FPUIE_CAUSE_INFOP 3
`define FPUIE_CAUSE_REM 4
`define FPUIE_CAUSE_TRIG 5
`define FPUIE_CAUSE_DOMAIN 6
`define FPUIE_CAUSE_RANGE 7
`endif

//--- fpuie_tag_slot.v
// One tag slot of the eight-entry register stack.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "fpuie_defines.vh"
module fpuie_tag_slot (
    input wire clock_i,
    input wire rst_i,
    input wire wr_i,
    input wire [1:0] tag_i,
    output reg [1:0] tag_o,
    output wire empty_o
);
    always @(posedge clock_i) begin
        if (rst_i) begin
            tag_o <= `FPUIE_TAG_EMPTY;
        end else if (wr_i) begin
            tag_o <= tag_i;
        end
    end
    // Tags 00, 01 and 10 all mean occupied
    assign empty_o = (tag_o == `FPUIE_TAG_EMPTY);
endmodule

//--- fpuie_invalid_unit.v
// Contract
// - Invalid flag at status bit 0, its mask at control bit 0.
// - Stack fault sets stack fault flag; arithmetic faults never clear it.
// - Tags 00, 01, 10 mean non-empty; 11 means empty.
// - Loading from memory into non-empty register is stack overflow.
// - Reading empty register as source, including store, is stack underflow.
// - Eight-entry stack wraps around.
// - Stack fault sets invalid flag and stack fault flag bit 6.
// - Condition bit one: 1 on overflow, 0 on underflow.
// - Masked stack fault writes indefinite of instruction's kind to destination.
// - Unmasked: raise handler, keep stack pointer and operands unchanged.
// - Invalid operand sets invalid flag, then masked or unmasked path.
// - Unsupported encoding, masked, returns QNaN indefinite.
// - Signalling NaN raises invalid, masked returns quiet NaN.
// - Ordered compare with NaN, masked, sets unordered 111B.
// - Infinity arithmetic conflicts raise invalid, masked return QNaN indefinite.
// - Remainder and trig faults return QNaN indefinite, clear condition bit two.
// - Bad square root or logarithm domain returns QNaN indefinite.
// - Bad packed-BCD store writes BCD indefinite.
// - Bad integer store writes integer indefinite.
// - Exchange fills empty registers with QNaN indefinite, then exchanges; the unit retags empty slots 10 but never swaps.
// - Quiet NaN alone raises nothing.
// - Compares and integer or BCD conversions fault on quiet NaN.
// - Summary flag set while any unmasked exception is pending.
// - Non-arithmetic instructions may still raise stack fault.
//
// Invalid-operation exception unit with AXI4-Lite register access.
// Assumes the pipeline classifies operands and reports cause bits.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fpuie_defines.vh"
module fpuie_invalid_unit (
    input wire clock_i,
    input wire rst_i,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg handler_req_o,
    output reg [31:0] result_o,
    output reg result_valid_o,
    output reg [2:0] int_flags_o
);
    reg [15:0] status_reg;
    reg [15:0] control_reg;
    reg [2:0] top_reg;
    reg [15:0] opcmd_reg;
    reg [31:0] opa_reg;
    reg [7:0] last_event_reg;
    reg [7:0] aw_addr_reg;
    reg aw_have_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_have_reg;
    reg [2:0] eval_reg;
    // Command fields: [3:0] op, [6:4] reg index, [7] push, [8] pop,
    // [9] int flags target, [15:10] unused and never decoded by the unit
    wire [3:0] op_code = opcmd_reg[3:0];
    wire [2:0] rel_idx = opcmd_reg[6:4];
    wire do_push = opcmd_reg[7];
    wire do_pop = opcmd_reg[8];
    wire to_int_flags = opcmd_reg[9];
    wire wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    wire cmd_start = wr_fire && (aw_addr_reg == `FPUIE_ADDR_OPCMD);
    wire masked = control_reg[`FPUIE_BIT_MASK];
    wire [7:0] cause = opa_reg[7:0];

    // Tag slots
    wire [7:0] slot_empty;
    wire [15:0] tag_word;
    reg [7:0] slot_wr;
    reg [1:0] slot_val;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_slot
            fpuie_tag_slot u_slot (
                .clock_i(clock_i),
                .rst_i(rst_i),
                .wr_i(slot_wr[g]),
                .tag_i(slot_val),
                .tag_o(tag_word[2*g+1:2*g]),
                .empty_o(slot_empty[g])
            );
        end
    endgenerate

    // Wraparound indices on the eight-entry stack
    wire [2:0] push_idx = top_reg - 3'd1;
    wire [2:0] src_idx = top_reg + rel_idx;
    wire over = (op_code == `FPUIE_OP_LOAD) && !slot_empty[push_idx];
    wire under = (op_code != `FPUIE_OP_LOAD) && (op_code != `FPUIE_OP_EXCHANGE)
        && slot_empty[src_idx];
    wire xch_empty = (op_code == `FPUIE_OP_EXCHANGE) && (slot_empty[top_reg] || slot_empty[src_idx]);
    wire stack_fault = over || under;
    // Quiet NaN only faults for compares and conversions
    wire qnan_fault = cause[`FPUIE_CAUSE_QNAN] && ((op_code == `FPUIE_OP_COMPARE)
        || (op_code == `FPUIE_OP_STORE_INT) || (op_code == `FPUIE_OP_STORE_BCD));
    wire arith_fault = (op_code != `FPUIE_OP_NONARITH) && ((cause & 8'hFB) != 8'h00 || qnan_fault);
    wire any_invalid = stack_fault || xch_empty || arith_fault;

    reg [31:0] res_next;
    reg res_wr;
    reg [15:0] status_next;
    reg handler_next;
    reg [2:0] top_next;
    reg [2:0] intf_next;
    always @* begin
        res_next = result_o;
        res_wr = 1'b0;
        status_next = status_reg;
        handler_next = 1'b0;
        top_next = top_reg;
        intf_next = int_flags_o;
        slot_wr = 8'h00;
        slot_val = 2'b00;
        if (eval_reg[0]) begin
            if (stack_fault) begin
                status_next[`FPUIE_BIT_INVALID] = 1'b1;
                status_next[`FPUIE_BIT_STACK_FAULT] = 1'b1;
                status_next[`FPUIE_BIT_COND_ONE] = over;
            end else if (any_invalid) begin
                status_next[`FPUIE_BIT_INVALID] = 1'b1;
            end
            if (any_invalid && !masked) begin
                handler_next = 1'b1;
            end else if (stack_fault) begin
                res_wr = 1'b1;
                if (op_code == `FPUIE_OP_STORE_INT) begin
                    res_next = `FPUIE_INT_INDEF;
                end else if (op_code == `FPUIE_OP_STORE_BCD) begin
                    res_next = `FPUIE_BCD_INDEF;
                end else begin
                    res_next = `FPUIE_QNAN_INDEF;
                end
                if (over) begin
                    top_next = push_idx;
                end
            end else if (xch_empty) begin
                // Empty sides become QNaN indefinite, tagged special
                res_wr = 1'b1;
                res_next = `FPUIE_QNAN_INDEF;
                slot_val = 2'b10;
                slot_wr[top_reg] = slot_empty[top_reg];
                slot_wr[src_idx] = slot_empty[src_idx];
            end else if (arith_fault) begin
                res_wr = 1'b1;
                if (op_code == `FPUIE_OP_STORE_INT) begin
                    res_next = `FPUIE_INT_INDEF;
                end else if (op_code == `FPUIE_OP_STORE_BCD) begin
                    res_next = `FPUIE_BCD_INDEF;
                end else if (op_code == `FPUIE_OP_COMPARE) begin
                    res_wr = 1'b0;
                    if (to_int_flags) begin
                        intf_next = 3'b111;
                    end else begin
                        status_next[`FPUIE_BIT_COND_ZERO] = 1'b1;
                        status_next[`FPUIE_BIT_COND_TWO] = 1'b1;
                        status_next[`FPUIE_BIT_COND_THREE] = 1'b1;
                    end
                end else if (cause[`FPUIE_CAUSE_SNAN] && !cause[`FPUIE_CAUSE_UNSUP]) begin
                    // Quiet the NaN by setting the top fraction bit
                    res_next = opa_reg | 32'h0040_0000;
                end else begin
                    res_next = `FPUIE_QNAN_INDEF;
                    if (cause[`FPUIE_CAUSE_REM] || cause[`FPUIE_CAUSE_TRIG]) begin
                        status_next[`FPUIE_BIT_COND_TWO] = 1'b0;
                    end
                end
            end else begin
                // Clean operation moves the stack
                if (do_push) begin
                    top_next = push_idx;
                    slot_val = 2'b00;
                    slot_wr[push_idx] = 1'b1;
                end else if (do_pop) begin
                    top_next = top_reg + 3'd1;
                    slot_val = 2'b11;
                    slot_wr[top_reg] = 1'b1;
                end
            end
        end
        // Summary follows pending unmasked invalid
        status_next[`FPUIE_BIT_SUMMARY] = status_next[`FPUIE_BIT_INVALID] && !masked;
    end

    always @(posedge clock_i) begin
        if (rst_i) begin
            status_reg <= `FPUIE_STATUS_RESET;
            control_reg <= `FPUIE_CONTROL_RESET;
            top_reg <= 3'd0;
            opcmd_reg <= 16'h0000;
            opa_reg <= 32'h0000_0000;
            last_event_reg <= 8'h00;
            eval_reg <= 3'b000;
            handler_req_o <= 1'b0;
            result_o <= 32'h0000_0000;
            result_valid_o <= 1'b0;
            int_flags_o <= 3'b000;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            eval_reg <= {eval_reg[1:0], cmd_start};
            status_reg <= status_next;
            top_reg <= top_next;
            int_flags_o <= intf_next;
            handler_req_o <= handler_next;
            result_valid_o <= res_wr;
            if (res_wr) begin
                result_o <= res_next;
            end
            if (eval_reg[0]) begin
                last_event_reg <= {3'b000, xch_empty, arith_fault, under, over, handler_next};
            end
            // Write address and data taken in either order
            s_axi_awready <= !aw_have_reg && !s_axi_awready;
            s_axi_wready <= !w_have_reg && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                case (aw_addr_reg)
                    `FPUIE_ADDR_STATUS: begin
                        // Software reload of bits 7:0 wins only where no event sets the flag this cycle; bits 15:8 take the written value
                        if (w_strb_reg[0]) begin
                            status_reg[7:0] <= w_data_reg[7:0] | (status_next[7:0] & ~status_reg[7:0]);
                        end
                        if (w_strb_reg[1]) begin
                            status_reg[15:8] <= w_data_reg[15:8];
                        end
                    end
                    `FPUIE_ADDR_CONTROL: begin
                        if (w_strb_reg[0]) begin
                            control_reg[7:0] <= w_data_reg[7:0];
                        end
                        if (w_strb_reg[1]) begin
                            control_reg[15:8] <= w_data_reg[15:8];
                        end
                    end
                    `FPUIE_ADDR_TOP: begin
                        if (w_strb_reg[0]) begin
                            top_reg <= w_data_reg[2:0];
                        end
                    end
                    `FPUIE_ADDR_OPCMD: begin
                        opcmd_reg <= w_data_reg[15:0];
                    end
                    `FPUIE_ADDR_OPA: begin
                        opa_reg <= w_data_reg;
                    end
                    default: begin
                        s_axi_bresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Read channel, one outstanding
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    `FPUIE_ADDR_STATUS: s_axi_rdata <= {16'h0000, status_reg[15:14], top_reg, status_reg[10:0]};
                    `FPUIE_ADDR_CONTROL: s_axi_rdata <= {16'h0000, control_reg};
                    `FPUIE_ADDR_TAG: s_axi_rdata <= {16'h0000, tag_word};
                    `FPUIE_ADDR_TOP: s_axi_rdata <= {29'h0000_0000, top_reg};
                    `FPUIE_ADDR_OPCMD: s_axi_rdata <= {16'h0000, opcmd_reg};
                    `FPUIE_ADDR_OPA: s_axi_rdata <= opa_reg;
                    `FPUIE_ADDR_RESULT: s_axi_rdata <= result_o;
                    `FPUIE_ADDR_EVENT: s_axi_rdata <= {21'h00_0000, int_flags_o, last_event_reg};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

//--- fpuie_monitor.sv
// Port checker for the invalid-operation unit.
// Bound to fpuie_invalid_unit; one clock, synchronous reset.
`timescale 1ns/1ps
module fpuie_monitor (
    input wire clock_i,
    input wire rst_i,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire handler_req_o,
    input wire result_valid_o,
    input wire [2:0] int_flags_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_aw_take; s_axi_awvalid && s_axi_awready; endsequence
    sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
    property p_handler_pulse; handler_req_o |=> !handler_req_o; endproperty
    a_handler_pulse: assert property (p_handler_pulse) else $error("handler request too long");
    property p_result_pulse; result_valid_o |=> !result_valid_o; endproperty
    a_result_pulse: assert property (p_result_pulse) else $error("result strobe too long");
    property p_trap_no_result; handler_req_o |-> !result_valid_o; endproperty
    a_trap_no_result: assert property (p_trap_no_result) else $error("result written on trap");
    property p_write_answer; s_aw_take |-> ##[1:4] s_axi_bvalid; endproperty
    a_write_answer: assert property (p_write_answer) else $error("write not answered");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_read_answer; s_ar_take |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_reset_quiet; $past(rst_i) |-> !handler_req_o && !result_valid_o && int_flags_o == 3'b000; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule
bind fpuie_invalid_unit fpuie_monitor u_fpuie_monitor (.clock_i(clock_i), .rst_i(rst_i),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .handler_req_o(handler_req_o), .result_valid_o(result_valid_o),
    .int_flags_o(int_flags_o));

//--- fpuie_handler_model.sv
// Pipeline-side model: counts handler invocations.
// Assumes a one-cycle handler request pulse.
`timescale 1ns/1ps
module fpuie_handler_model (
    input wire clock_i,
    input wire rst_i,
    input wire handler_req_i,
    output reg [7:0] handler_count_o
);
    always @(posedge clock_i) begin
        if (rst_i) begin
            handler_count_o <= 8'h00;
        end else if (handler_req_i) begin
            handler_count_o <= handler_count_o + 8'h01;
        end
    end
endmodule

//--- testbench.sv
// Self-checking bench for the invalid-operation unit.
// Assumes the register map and op encoding of the shared defines.
`timescale 1ns/1ps
`include "fpuie_defines.vh"
module testbench;
    reg clock_i = 1'b0;
    reg rst_i = 1'b1;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0000_0000;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, handler_req_o, result_valid_o;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, result_o;
    wire [2:0] int_flags_o;
    wire [7:0] handler_count;
    integer n_mismatch = 0, n_tests = 0, cycles = 0, i;
    logic [31:0] exp_rd[$], msk_rd[$], exp_res[$], msk_res[$];
    logic [1:0] exp_rr[$];
    reg [3:0] ops [0:2];
    reg [31:0] inds [0:2];
    reg [2:0] idx;
    always #4 clock_i = ~clock_i;
    fpuie_invalid_unit u_fpuie_invalid_unit (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .handler_req_o(handler_req_o), .result_o(result_o), .result_valid_o(result_valid_o),
        .int_flags_o(int_flags_o));
    fpuie_handler_model u_fpuie_handler_model (.clock_i(clock_i), .rst_i(rst_i), .handler_req_i(handler_req_o),
        .handler_count_o(handler_count));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task do_reset;
        begin
            rst_i <= 1'b1;
            repeat (5) @(posedge clock_i);
            rst_i <= 1'b0;
            @(posedge clock_i);
        end
    endtask
    // Address and data offered together, each dropped on its own ready
    task wr(input [7:0] a, input [31:0] d, input [1:0] resp);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            @(posedge clock_i);
            while (s_axi_awvalid || s_axi_wvalid) begin
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                @(posedge clock_i);
            end
            repeat ($urandom_range(2, 0)) @(posedge clock_i);
            s_axi_bready <= 1'b1;
            @(posedge clock_i);
            while (!s_axi_bvalid) @(posedge clock_i);
            s_axi_bready <= 1'b0;
            chk(s_axi_bresp, resp);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e, input [31:0] m);
        begin
            exp_rd.push_back(e & m);
            msk_rd.push_back(m);
            exp_rr.push_back((a > `FPUIE_ADDR_EVENT) ? 2'b10 : 2'b00);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            @(posedge clock_i);
            while (!s_axi_arready) @(posedge clock_i);
            s_axi_arvalid <= 1'b0;
            // Late rready makes the slave hold its answer
            repeat ($urandom_range(2, 0)) @(posedge clock_i);
            s_axi_rready <= 1'b1;
            @(posedge clock_i);
            while (!s_axi_rvalid) @(posedge clock_i);
            s_axi_rready <= 1'b0;
        end
    endtask
    // Operand has an all-ones exponent so a quieted signalling NaN stays a NaN
    task op(input [7:0] cause, input [9:0] cmd, input [31:0] res, input [31:0] m);
        reg [31:0] rv;
        begin
            rv = $urandom;
            if (m != 32'h0000_0000) begin
                exp_res.push_back(res & m);
                msk_res.push_back(m);
            end
            wr(`FPUIE_ADDR_OPA, {rv[31], 8'hff, rv[22:8], cause}, 2'b00);
            wr(`FPUIE_ADDR_OPCMD, {22'h00_0000, cmd}, 2'b00);
            repeat (4) @(posedge clock_i);
        end
    endtask
    always @(posedge clock_i) begin
        cycles = cycles + 1;
        if (s_axi_rvalid && s_axi_rready) chk(s_axi_rdata & msk_rd.pop_front(), exp_rd.pop_front());
        if (s_axi_rvalid && s_axi_rready) chk(s_axi_rresp, exp_rr.pop_front());
        if (result_valid_o && exp_res.size() == 0) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, result_o, 32'h0000_0000);
        end else if (result_valid_o) begin
            chk(result_o & msk_res.pop_front(), exp_res.pop_front());
        end
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end
    initial begin
        i = $urandom(32'ha55b_e292);
        ops[0] = `FPUIE_OP_STORE_FP;
        ops[1] = `FPUIE_OP_STORE_INT;
        ops[2] = `FPUIE_OP_STORE_BCD;
        inds[0] = `FPUIE_QNAN_INDEF;
        inds[1] = `FPUIE_INT_INDEF;
        inds[2] = `FPUIE_BCD_INDEF;
        do_reset;
        rd(`FPUIE_ADDR_STATUS, 32'h0000_0000, 32'h0000_ffff);
        rd(`FPUIE_ADDR_CONTROL, 32'h0000_0001, 32'h0000_ffff);
        rd(`FPUIE_ADDR_TAG, 32'h0000_ffff, 32'h0000_ffff);
        wr(`FPUIE_ADDR_TAG, 32'h0000_0000, 2'b10);
        wr(8'h20, 32'h0000_0000, 2'b10);
        rd(8'h20, 32'h0000_0000, 32'hffff_ffff);
        for (i = 0; i < 3; i = i + 1) begin
            idx = $urandom_range(7, 0);
            op(8'h00, {3'b000, idx, ops[i]}, inds[i], 32'hffff_ffff);
            rd(`FPUIE_ADDR_STATUS, 32'h0000_0041, 32'h0000_0241);
        end
        op(8'h00, {3'b000, idx, `FPUIE_OP_EXCHANGE}, `FPUIE_QNAN_INDEF, 32'hffff_ffff);
        // Exchange fills empty slots, so a fresh reset empties the stack again
        do_reset;
        for (i = 0; i < 8; i = i + 1) op(8'h00, {3'b001, 3'd0, `FPUIE_OP_LOAD}, 32'h0000_0000, 32'h0000_0000);
        rd(`FPUIE_ADDR_STATUS, 32'h0000_0000, 32'h0000_0041);
        op(8'h00, {3'b001, 3'd0, `FPUIE_OP_LOAD}, `FPUIE_QNAN_INDEF, 32'hffff_ffff);
        rd(`FPUIE_ADDR_STATUS, 32'h0000_0241, 32'h0000_0241);
        for (i = 0; i < 7; i = i + 1) begin
            if (i != 1 && i != 2) begin
                op(8'h01 << i, {6'b000000, `FPUIE_OP_ARITH}, `FPUIE_QNAN_INDEF, 32'hffff_ffff);
                rd(`FPUIE_ADDR_STATUS, 32'h0000_0041, 32'h0000_0441);
            end
        end
        op(8'h02, {6'b000000, `FPUIE_OP_ARITH}, 32'h7fc0_0000, 32'h7fc0_0000);
        wr(`FPUIE_ADDR_STATUS, 32'h0000_0000, 2'b00);
        rd(`FPUIE_ADDR_STATUS, 32'h0000_0000, 32'h0000_0041);
        op(8'h04, {6'b000000, `FPUIE_OP_ARITH}, 32'h0000_0000, 32'h0000_0000);
        rd(`FPUIE_ADDR_STATUS, 32'h0000_0000, 32'h0000_0001);
        op(8'h04, {3'b100, 3'd0, `FPUIE_OP_COMPARE}, 32'h0000_0000, 32'h0000_0000);
        chk(int_flags_o, 3'b111);
        op(8'h04, {6'b000000, `FPUIE_OP_COMPARE}, 32'h0000_0000, 32'h0000_0000);
        rd(`FPUIE_ADDR_STATUS, 32'h0000_4501, 32'h0000_4501);
        op(8'h10, {6'b000000, `FPUIE_OP_ARITH}, `FPUIE_QNAN_INDEF, 32'hffff_ffff);
        rd(`FPUIE_ADDR_STATUS, 32'h0000_4101, 32'h0000_4501);
        op(8'h80, {6'b000000, `FPUIE_OP_STORE_INT}, `FPUIE_INT_INDEF, 32'hffff_ffff);
        op(8'h04, {6'b000000, `FPUIE_OP_STORE_BCD}, `FPUIE_BCD_INDEF, 32'hffff_ffff);
        wr(`FPUIE_ADDR_CONTROL, 32'h0000_0000, 2'b00);
        wr(`FPUIE_ADDR_STATUS, 32'h0000_0000, 2'b00);
        rd(`FPUIE_ADDR_TOP, 32'h0000_0007, 32'h0000_0007);
        op(8'h00, {3'b001, 3'd0, `FPUIE_OP_LOAD}, 32'h0000_0000, 32'h0000_0000);
        rd(`FPUIE_ADDR_TOP, 32'h0000_0007, 32'h0000_0007);
        rd(`FPUIE_ADDR_STATUS, 32'h0000_02c1, 32'h0000_02c1);
        op(8'h01, {6'b000000, `FPUIE_OP_ARITH}, 32'h0000_0000, 32'h0000_0000);
        chk(handler_count, 32'h0000_0002);
        chk(exp_res.size(), 32'h0000_0000);
        stop_test;
    end
endmodule
